// File: include/trig_pos_regs.svh
// Purpose: Offsets, fields, reset values and counts for trigger position control
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Included by the design file and the bench
`ifndef TRIG_POS_REGS_SVH
`define TRIG_POS_REGS_SVH

// Register byte offsets
`define OFF_CTRL 12'h000
`define OFF_POS 12'h004
`define OFF_SAMPLES 12'h008
`define OFF_VIDEO 12'h00c
`define OFF_LED 12'h010
`define OFF_STATUS 12'h014
`define OFF_IRQ_STAT 12'h018
`define OFF_IRQ_MASK 12'h01c
`define OFF_TRIG_TIME 12'h020
`define OFF_TRIG_ADDR 12'h024

// Control fields
`define CTRL_ARM 0
`define CTRL_SRC_LO 1
`define CTRL_SRC_HI 3
`define CTRL_EXT 4
`define CTRL_SLOPE_NEG 5
`define CTRL_COUPLE_AC 6
`define CTRL_VIDEO 7
`define CTRL_ABORT 8

// Video fields
`define VID_LINE_HI 9
`define VID_FIELD_ODD 10
`define VID_STD_525 11

// Led fields
`define LED_OVERRIDE 0
`define LED_RED 1
`define LED_GREEN 2

// Interrupt bits
`define IRQ_TRIG 0
`define IRQ_DONE 1

// Positioning and memory
`define POS_STEP_LOG2 4
`define MEM_AW 16
`define POST_MAX_SAMPLES 32'd100000000
`define CH_NUM 8

// Interpolator: 0.2 % of a sample interval is 1/500
`define INTERP_STEPS 10'd500

// Reset values
`define RST_CTRL 32'h0000_0000
`define RST_SAMPLES 32'h0000_1000

`endif

// File: include/trig_pos_pkg.sv
// Purpose: Types for trigger position control
// Assumes: Header holds all numbers
// Notes: State machine of the acquisition sequencer
package trig_pos_pkg;
    // Acquisition sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FILL,
        ST_ARMED,
        ST_DELAY,
        ST_STORE,
        ST_DONE
    } acq_state_t;
endpackage

// File: rtl/trigger_position_control.sv
// Purpose: Trigger select, slope, video trigger, pre/post positioning, indicator
// Assumes: Comparator and sync separator outputs are synchronous to clk (sample clock)
// Notes: Analog coupling and level tracking live outside; this block drives their selects
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ns
`include "trig_pos_regs.svh"

module trigger_position_control
    import trig_pos_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Comparator outputs, one per channel plus external
    input wire logic [`CH_NUM-1:0] chan_above,
    input wire logic ext_above,
    // Video sync separator
    input wire logic vid_line_start,
    input wire logic vid_field_odd,
    // Fine phase of trigger within sample, in interpolator steps
    input wire logic [9:0] interp_phase,
    // Readout done from acquisition memory side
    input wire logic readout_done,
    // Analog front-end selects
    output logic couple_ac,
    output logic auto_level,
    // Memory write side
    output logic mem_we,
    output logic [`MEM_AW-1:0] mem_addr,
    // Indicator and interrupt
    output logic led_green,
    output logic led_red,
    output logic irq
);

    // Software registers
    logic [31:0] ctrl_ff;
    logic [31:0] pos_ff; // Signed: positive post, negative pre
    logic [31:0] samples_ff;
    logic [31:0] video_ff;
    logic [2:0] led_ff;
    logic [1:0] irq_stat_ff;
    logic [1:0] irq_mask_ff;
    // Sequencer state
    acq_state_t state_ff;
    logic [31:0] cnt_ff;
    logic [`MEM_AW-1:0] wr_ptr_ff;
    logic [`MEM_AW-1:0] trig_addr_ff;
    logic [9:0] trig_time_ff;
    logic level_d_ff;
    logic [9:0] line_cnt_ff;
    logic field_ok_ff;
    logic armed_led_ff;
    logic done_led_ff;

    // APB decode
    logic wr_en;
    logic rd_en;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign pready = 1'b1;

    // Address is mapped if it hits any register
    function automatic logic mapped(input logic [11:0] a);
        mapped = (a <= `OFF_TRIG_ADDR) && (a[1:0] == 2'b00);
    endfunction

    assign pslverr = psel && penable && !mapped(paddr);

    // Chosen trigger level from channel or external, never other inputs
    logic src_level;
    always_comb begin
        if (ctrl_ff[`CTRL_EXT] || ctrl_ff[`CTRL_VIDEO]) begin
            src_level = ext_above;
        end else begin
            src_level = chan_above[ctrl_ff[`CTRL_SRC_HI:`CTRL_SRC_LO]];
        end
    end

    // Edge detection on the selected level
    logic edge_hit;
    assign edge_hit = ctrl_ff[`CTRL_SLOPE_NEG] ? (level_d_ff && !src_level)
                                               : (!level_d_ff && src_level);

    // Video trigger: line counter matched, field parity matched
    logic vid_hit;
    logic [9:0] lines_per_field;
    assign lines_per_field = video_ff[`VID_STD_525] ? 10'd263 : 10'd313;
    assign vid_hit = vid_line_start && field_ok_ff
                     && (line_cnt_ff == video_ff[`VID_LINE_HI:0]);

    logic trig_evt;
    assign trig_evt = ctrl_ff[`CTRL_VIDEO] ? vid_hit : edge_hit;

    // Coupling selects; video forces AC
    assign couple_ac = ctrl_ff[`CTRL_COUPLE_AC] || ctrl_ff[`CTRL_VIDEO];
    assign auto_level = couple_ac;

    // Positioning in 16-sample steps
    logic pos_neg;
    logic [31:0] pre_cnt;
    logic [31:0] post_cnt;
    logic [31:0] pos_mag;
    assign pos_neg = pos_ff[31];
    assign pos_mag = pos_neg ? (32'd0 - pos_ff) : pos_ff;
    // Clamp pre to window, post to the maximum, and drop the low step bits
    always_comb begin
        pre_cnt = 32'd0;
        post_cnt = 32'd0;
        if (pos_neg) begin
            pre_cnt = (pos_mag > samples_ff) ? samples_ff : pos_mag;
            pre_cnt = {pre_cnt[31:`POS_STEP_LOG2], 4'h0};
        end else begin
            post_cnt = (pos_mag > `POST_MAX_SAMPLES) ? `POST_MAX_SAMPLES : pos_mag;
            post_cnt = {post_cnt[31:`POS_STEP_LOG2], 4'h0};
        end
    end

    // Samples stored after the trigger
    logic [31:0] after_cnt;
    assign after_cnt = samples_ff - pre_cnt;

    // Register writes for control and configuration
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl_ff <= `RST_CTRL;
            pos_ff <= 32'h0000_0000;
            samples_ff <= `RST_SAMPLES;
            video_ff <= 32'h0000_0000;
            led_ff <= 3'h0;
            irq_mask_ff <= 2'h0;
        end else begin
            // Arm and abort are self-clearing strobes
            ctrl_ff[`CTRL_ARM] <= 1'b0;
            ctrl_ff[`CTRL_ABORT] <= 1'b0;
            if (wr_en && paddr == `OFF_CTRL) begin
                ctrl_ff <= pwdata;
            end else if (wr_en && paddr == `OFF_POS) begin
                pos_ff <= pwdata;
            end else if (wr_en && paddr == `OFF_SAMPLES) begin
                samples_ff <= pwdata;
            end else if (wr_en && paddr == `OFF_VIDEO) begin
                video_ff <= pwdata;
            end else if (wr_en && paddr == `OFF_LED) begin
                led_ff <= pwdata[2:0];
            end else if (wr_en && paddr == `OFF_IRQ_MASK) begin
                irq_mask_ff <= pwdata[1:0];
            end
        end
    end

    // Previous level for edge detection
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            level_d_ff <= 1'b0;
        end else begin
            level_d_ff <= src_level;
        end
    end

    // Video line counter within a field, field parity latch
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            line_cnt_ff <= 10'h000;
            field_ok_ff <= 1'b0;
        end else if (vid_line_start) begin
            if (line_cnt_ff >= lines_per_field - 10'd1) begin
                line_cnt_ff <= 10'h000;
                field_ok_ff <= (vid_field_odd == video_ff[`VID_FIELD_ODD]);
            end else begin
                line_cnt_ff <= line_cnt_ff + 10'd1;
            end
        end
    end

    // Acquisition sequencer
    logic seq_done_evt;
    logic seq_trig_evt;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_ff <= ST_IDLE;
            cnt_ff <= 32'h0000_0000;
            wr_ptr_ff <= '0;
            trig_addr_ff <= '0;
            trig_time_ff <= 10'h000;
        end else if (ctrl_ff[`CTRL_ABORT]) begin
            state_ff <= ST_IDLE;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (ctrl_ff[`CTRL_ARM]) begin
                        wr_ptr_ff <= '0;
                        cnt_ff <= pre_cnt;
                        state_ff <= (pre_cnt == 32'd0) ? ST_ARMED : ST_FILL;
                    end
                end
                // Fill the pre-trigger part before accepting a trigger
                ST_FILL: begin
                    wr_ptr_ff <= wr_ptr_ff + 1'b1;
                    if (cnt_ff <= 32'd1) begin
                        state_ff <= ST_ARMED;
                    end
                    cnt_ff <= cnt_ff - 32'd1;
                end
                ST_ARMED: begin
                    if (pre_cnt != 32'd0) begin
                        wr_ptr_ff <= wr_ptr_ff + 1'b1;
                    end
                    if (trig_evt) begin
                        trig_time_ff <= (interp_phase >= `INTERP_STEPS)
                            ? (`INTERP_STEPS - 10'd1) : interp_phase;
                        trig_addr_ff <= wr_ptr_ff;
                        if (post_cnt != 32'd0) begin
                            cnt_ff <= post_cnt;
                            state_ff <= ST_DELAY;
                        end else begin
                            cnt_ff <= after_cnt;
                            state_ff <= (after_cnt == 32'd0) ? ST_DONE : ST_STORE;
                        end
                    end
                end
                // Post delay elapses without storing
                ST_DELAY: begin
                    cnt_ff <= cnt_ff - 32'd1;
                    if (cnt_ff == 32'd1) begin
                        cnt_ff <= samples_ff;
                        state_ff <= ST_STORE;
                    end
                end
                // Remaining samples after the trigger then stop
                ST_STORE: begin
                    wr_ptr_ff <= wr_ptr_ff + 1'b1;
                    cnt_ff <= cnt_ff - 32'd1;
                    if (cnt_ff <= 32'd1) begin
                        state_ff <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    if (readout_done) begin
                        state_ff <= ST_IDLE;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    assign seq_trig_evt = (state_ff == ST_ARMED) && trig_evt && !ctrl_ff[`CTRL_ABORT];
    // Full pre-trigger goes straight from armed to done, so it must raise done too
    assign seq_done_evt = !ctrl_ff[`CTRL_ABORT]
                          && (((state_ff == ST_STORE) && (cnt_ff <= 32'd1))
                              || (seq_trig_evt && (post_cnt == 32'd0)
                                  && (after_cnt == 32'd0)));

    // Memory write port follows the sequencer
    assign mem_we = (state_ff == ST_FILL) || (state_ff == ST_STORE)
                    || ((state_ff == ST_ARMED) && (pre_cnt != 32'd0));
    assign mem_addr = wr_ptr_ff;

    // Indicator state from the sequencer, registered
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            armed_led_ff <= 1'b0;
            done_led_ff <= 1'b0;
        end else begin
            armed_led_ff <= (state_ff == ST_ARMED);
            done_led_ff <= (state_ff == ST_DONE);
        end
    end

    // Override selects the programmed colour
    assign led_green = led_ff[`LED_OVERRIDE] ? led_ff[`LED_GREEN] : armed_led_ff;
    assign led_red = led_ff[`LED_OVERRIDE] ? led_ff[`LED_RED] : done_led_ff;

    // Sticky interrupt status; a set beats a write-one clear
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irq_stat_ff <= 2'h0;
        end else begin
            irq_stat_ff[`IRQ_TRIG] <= seq_trig_evt
                || (irq_stat_ff[`IRQ_TRIG]
                    && !(wr_en && paddr == `OFF_IRQ_STAT && pwdata[`IRQ_TRIG]));
            irq_stat_ff[`IRQ_DONE] <= seq_done_evt
                || (irq_stat_ff[`IRQ_DONE]
                    && !(wr_en && paddr == `OFF_IRQ_STAT && pwdata[`IRQ_DONE]));
        end
    end

    assign irq = |(irq_stat_ff & irq_mask_ff);

    // Read data, registered for the zero-wait answer
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == `OFF_CTRL) begin
                prdata <= ctrl_ff;
            end else if (paddr == `OFF_POS) begin
                prdata <= pos_ff;
            end else if (paddr == `OFF_SAMPLES) begin
                prdata <= samples_ff;
            end else if (paddr == `OFF_VIDEO) begin
                prdata <= video_ff;
            end else if (paddr == `OFF_LED) begin
                prdata <= {29'h0, led_ff};
            end else if (paddr == `OFF_STATUS) begin
                prdata <= {29'h0, state_ff};
            end else if (paddr == `OFF_IRQ_STAT) begin
                prdata <= {30'h0, irq_stat_ff};
            end else if (paddr == `OFF_IRQ_MASK) begin
                prdata <= {30'h0, irq_mask_ff};
            end else if (paddr == `OFF_TRIG_TIME) begin
                prdata <= {22'h0, trig_time_ff};
            end else if (paddr == `OFF_TRIG_ADDR) begin
                prdata <= {16'h0, trig_addr_ff};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Checks
    step_align_a: assert property (@(posedge clk) disable iff (!reset_n)
        pre_cnt[3:0] == 4'h0 && post_cnt[3:0] == 4'h0)
        else $error("position not in 16-sample steps");
    video_ac_a: assert property (@(posedge clk) disable iff (!reset_n)
        ctrl_ff[`CTRL_VIDEO] |-> couple_ac && auto_level)
        else $error("video trigger without ac coupling");
    pre_window_a: assert property (@(posedge clk) disable iff (!reset_n)
        pre_cnt <= samples_ff)
        else $error("pre-trigger beyond window");
    post_max_a: assert property (@(posedge clk) disable iff (!reset_n)
        post_cnt <= `POST_MAX_SAMPLES)
        else $error("post delay beyond maximum");
    delay_nostore_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_ff == ST_DELAY |-> !mem_we)
        else $error("storing during post delay");
    trig_time_a: assert property (@(posedge clk) disable iff (!reset_n)
        seq_trig_evt |=> trig_time_ff < `INTERP_STEPS)
        else $error("trigger time out of range");
    led_green_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_ff == ST_ARMED && !led_ff[`LED_OVERRIDE]) ##1 !led_ff[`LED_OVERRIDE]
        |-> led_green)
        else $error("green not shown while armed");
    led_red_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_ff == ST_DONE) ##1 !led_ff[`LED_OVERRIDE] |-> led_red)
        else $error("red not shown when done");
    done_stop_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_ff == ST_DONE |-> !mem_we)
        else $error("writing after acquisition done");
    // Direction of the level change must match the programmed slope
    slope_a: assert property (@(posedge clk) disable iff (!reset_n)
        (!ctrl_ff[`CTRL_VIDEO] && edge_hit)
        |-> (src_level == !ctrl_ff[`CTRL_SLOPE_NEG])
            && (level_d_ff == ctrl_ff[`CTRL_SLOPE_NEG]))
        else $error("edge in the wrong direction");
    done_irq_a: assert property (@(posedge clk) disable iff (!reset_n)
        seq_done_evt |=> irq_stat_ff[`IRQ_DONE])
        else $error("done flag not raised at end of record");
    cov_pre_c: cover property (@(posedge clk) state_ff == ST_FILL ##[1:50] state_ff == ST_DONE);
    cov_post_c: cover property (@(posedge clk) state_ff == ST_DELAY ##1 state_ff == ST_STORE);
    cov_vid_c: cover property (@(posedge clk) ctrl_ff[`CTRL_VIDEO] && seq_trig_evt);
    cov_full_pre_c: cover property (@(posedge clk)
        seq_trig_evt && post_cnt == 32'd0 && after_cnt == 32'd0);

endmodule // trigger_position_control

// File: verification/trigger_position_control_bench.sv
// Purpose: Self-checking bench for trigger position control
// Assumes: Zero wait state APB; irq on the done flag marks the end of a record
// Notes: Delays are compared with a zero-position baseline so fixed latency cancels
`timescale 1ns/1ns
`include "trig_pos_regs.svh"

module trigger_position_control_bench;
    // Clock, reset and APB master side
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr;
    // Comparators, sync separator, interpolator, readout
    logic [7:0] chan_above = 8'h00;
    logic ext_above = 1'b0;
    logic vid_line_start = 1'b0;
    logic vid_field_odd = 1'b0;
    logic [9:0] interp_phase = 10'h000;
    logic readout_done = 1'b0;
    // Design outputs
    logic couple_ac, auto_level, mem_we, led_green, led_red, irq;
    logic [15:0] mem_addr;
    // Score keeping and random state
    int errors = 0;
    int checks = 0;
    int cyc = 0;
    integer seed = 32'h771cdfb6;

    trigger_position_control trigger_position_control_inst (
        .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chan_above(chan_above), .ext_above(ext_above),
        .vid_line_start(vid_line_start), .vid_field_odd(vid_field_odd),
        .interp_phase(interp_phase), .readout_done(readout_done), .couple_ac(couple_ac),
        .auto_level(auto_level), .mem_we(mem_we), .mem_addr(mem_addr),
        .led_green(led_green), .led_red(led_red), .irq(irq)
    );

    // 100 MHz sample clock
    always #5 clk = ~clk;

    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            errors++;
            final_report();
        end
    end

    task automatic final_report;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Single comparison point
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer; ends 1 ns after the completing edge so outputs have settled
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic e;
        apb(1'b1, a, d, x, e);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        logic e;
        apb(1'b0, a, 32'h0, d, e);
    endtask

    // Selected source to vs, every other source to vo, all in one time step
    task automatic lines(input logic [2:0] s, input logic e, input logic vs, input logic vo);
        for (int i = 0; i < 8; i++) chan_above[i] <= (!e && i == s) ? vs : vo;
        ext_above <= e ? vs : vo;
    endtask

    // One armed record; t is trigger-to-done cycles, n the writes after the trigger
    task automatic run(input int samp, input int pos, output int t, output int n);
        logic [31:0] d;
        logic [2:0] src;
        logic ext, neg, f;
        int k, phase;
        src = $random(seed);
        ext = $random(seed);
        neg = $random(seed);
        f = ~neg;
        phase = {$random(seed)} % 500;
        wr(`OFF_SAMPLES, samp);
        wr(`OFF_POS, pos);
        wr(`OFF_IRQ_MASK, 32'h2);
        lines(src, ext, f, f);
        wr(`OFF_CTRL, 32'({neg, ext, src, 1'b1}));
        // A firing edge while still filling must be ignored
        if (pos < 0) begin
            lines(src, ext, ~f, f);
            @(posedge clk);
            lines(src, ext, f, f);
        end
        k = 0;
        do begin
            rd(`OFF_STATUS, d);
            k++;
        end while (d !== 32'h2 && k < 100);
        check("armed", d, 32'h2);
        check("armed led", {led_red, led_green}, 2'b01);
        // Wrong direction on the source, then firing edges on unselected inputs
        lines(src, ext, ~f, ~f);
        @(posedge clk);
        lines(src, ext, ~f, f);
        repeat (3) @(posedge clk);
        rd(`OFF_STATUS, d);
        check("no false trigger", d, 32'h2);
        @(posedge clk);
        interp_phase <= 10'(phase);
        lines(src, ext, f, f);
        t = 0;
        n = 0;
        while (irq !== 1'b1 && t < 3000) begin
            @(posedge clk);
            #1;
            t++;
            if (mem_we === 1'b1) n++;
        end
        rd(`OFF_STATUS, d);
        check("done state", d, 32'h5);
        check("done led", {led_red, led_green}, 2'b10);
        rd(`OFF_TRIG_TIME, d);
        check("trigger time", d, phase);
        rd(`OFF_IRQ_STAT, d);
        check("done flag", 32'(d[1]), 32'h1);
        wr(`OFF_IRQ_MASK, 32'h0);
        check("masked irq", 32'(irq), 32'h0);
        wr(`OFF_IRQ_MASK, 32'h2);
        check("unmasked irq", 32'(irq), 32'h1);
        wr(`OFF_IRQ_STAT, 32'h3);
        check("cleared irq", 32'(irq), 32'h0);
        @(posedge clk);
        readout_done <= 1'b1;
        @(posedge clk);
        readout_done <= 1'b0;
        rd(`OFF_STATUS, d);
        check("idle after readout", d, 32'h0);
        check("led after readout", 32'(led_red), 32'h0);
    endtask

    initial begin
        logic [31:0] d;
        logic e;
        int samp, bt, bn, t, n, p, pre, post;
        int tab[6];
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        rd(`OFF_CTRL, d);
        check("ctrl reset", d, `RST_CTRL);
        rd(`OFF_SAMPLES, d);
        check("samples reset", d, `RST_SAMPLES);
        rd(`OFF_STATUS, d);
        check("status reset", d, 32'h0);
        check("irq reset", 32'(irq), 32'h0);
        apb(1'b1, 12'h028, 32'hffff_ffff, d, e);
        check("unmapped write", 32'(e), 32'h1);
        apb(1'b0, 12'h028, 32'h0, d, e);
        check("unmapped read", {d[30:0], e}, 32'h1);
        // Every coupling and video combination
        for (int i = 0; i < 4; i++) begin
            wr(`OFF_CTRL, (32'(i) << 6) | ({$random(seed)} & 32'h3e));
            check("couple", {couple_ac, auto_level}, {2{i != 0}});
        end
        wr(`OFF_CTRL, 32'h0);
        wr(`OFF_LED, 32'h3);
        check("led red override", {led_red, led_green}, 2'b10);
        wr(`OFF_LED, 32'h5);
        check("led green override", {led_red, led_green}, 2'b01);
        wr(`OFF_LED, 32'h0);
        // Abort while armed
        wr(`OFF_POS, 32'h0);
        wr(`OFF_CTRL, 32'h1);
        wr(`OFF_CTRL, 32'h100);
        rd(`OFF_STATUS, d);
        check("abort", d, 32'h0);
        // Baseline, then post, truncated, pre, full and clamped pre positions
        samp = 48 + 16 * ({$random(seed)} % 6);
        run(samp, 0, bt, bn);
        tab = '{16, 23, -16, -40, -samp, -samp - 16};
        for (int i = 0; i < 6; i++) begin
            p = tab[i];
            post = (p > 0) ? (p & ~15) : 0;
            pre = (p < 0) ? (((-p) & ~15) > samp ? samp : ((-p) & ~15)) : 0;
            run(samp, p, t, n);
            check("record end time", t, bt + post - pre);
            check("writes after trigger", n, bn - pre);
        end
        // Video trigger on line 5; the first field only latches the parity
        wr(`OFF_POS, 32'h0);
        wr(`OFF_VIDEO, 32'h0000_0c05);
        vid_field_odd <= 1'b1;
        wr(`OFF_CTRL, 32'h81);
        @(posedge clk);
        vid_line_start <= 1'b1;
        t = 0;
        n = 0;
        while (irq !== 1'b1 && t < 3000) begin
            @(posedge clk);
            #1;
            t++;
            if (mem_we === 1'b1) n++;
        end
        vid_line_start <= 1'b0;
        // 263 lines per field in the 525-line standard, then line 5 of the next
        check("video record time", t, bt + 263 + 5);
        check("video writes", n, bn);
        rd(`OFF_STATUS, d);
        check("video done", d, 32'h5);
        wr(`OFF_IRQ_STAT, 32'h3);
        final_report();
    end
endmodule // trigger_position_control_bench
